// >>> include/trig_route_defs.svh
`ifndef TRIG_ROUTE_DEFS_SVH
`define TRIG_ROUTE_DEFS_SVH

// ==========================================================
// converter operating mode encodings
`define MODE_SEQUENTIAL        2'h0
`define MODE_PARALLEL          2'h1
`define MODE_PARALLEL_INDEP    2'h2

// ==========================================================
// pwm output source select encodings
`define PWM_SRC_GENERATOR      3'h0
`define PWM_SRC_LIMIT          3'h1
`define PWM_SRC_TIMER          3'h2
`define PWM_SRC_GPIO           3'h3

// ==========================================================
// reset values of the routing selects, and the pwm channel count
`define RESET_TIMER_SEL        1'h0
`define RESET_PWM_SRC          3'h0
`define PWM_CHANNELS           6

`endif

// >>> include/trig_route_pkg.sv
`default_nettype none

package trig_route_pkg;

  // ========================================================
  // types
  typedef logic [1:0] conv_mode_t;
  typedef logic [2:0] pwm_src_t;

endpackage : trig_route_pkg

`default_nettype wire

// >>> core/pin_sync3.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// three-stage synchroniser; output changes when stages 2 and 3 agree
module pin_sync3
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // pin in, clean level out
  input  wire logic pin_i,
  output logic      level_o
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic       level_reg;
  logic       level_next;

  // shift chain and agreement filter
  always_comb
  begin
    stage_next = {stage_reg[1:0], pin_i};
    level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage_reg <= 3'h0;
      level_reg <= 1'h0;
    end
    else
    begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule : pin_sync3

`default_nettype wire

// >>> core/trig_route.sv
// Overview of operation
// - pwm reload pulse selectable as timer channel-3 input
// - timer channel 3 output drives master trigger
// - timer channel 2 output drives converter b trigger
// - master trigger starts both converters, seq/parallel
// - b trigger starts converter b, parallel independent
// - limits, timers, gpio may drive pwm outputs
// - selects come from system integration control bits
// - active-low asserted low, active-high asserted high
`timescale 1ns/100ps
`default_nettype none
`include "trig_route_defs.svh"

module trig_route
(
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  // system integration control bits
  input  wire logic                       timer_sel_reload_i,
  input  wire trig_route_pkg::conv_mode_t conv_mode_i,
  input  wire trig_route_pkg::pwm_src_t   pwm_src_i,
  // timer module a
  input  wire logic                       timer_ch3_pin_i,
  input  wire logic                       timer_ch2_out_i,
  input  wire logic                       timer_ch3_out_i,
  output logic                            timer_ch3_in_o,
  // pwm generator
  input  wire logic                       pwm_reload_sync_i,
  input  wire logic [5:0]                 pwm_gen_i,
  output logic [5:0]                      pwm_out_o,
  // pwm alternative sources
  input  wire logic [5:0]                 conv_over_limit_i,
  input  wire logic [5:0]                 conv_under_limit_i,
  input  wire logic [5:0]                 timer_out_i,
  input  wire logic [5:0]                 gpio_pin_i,
  // converter starts and triggers
  output logic                            conv_a_start_o,
  output logic                            conv_b_start_o,
  output logic                            conv_master_trig_o,
  output logic                            conv_b_trig_o
);
  import trig_route_pkg::*;

  // ========================================================
  // state
  logic       sel_reg;
  logic       sel_next;
  conv_mode_t mode_reg;
  conv_mode_t mode_next;
  pwm_src_t   src_reg;
  pwm_src_t   src_next;
  logic       ch3_prev_reg;
  logic       ch3_prev_next;
  logic       ch2_prev_reg;
  logic       ch2_prev_next;
  logic       a_start_reg;
  logic       a_start_next;
  logic       b_start_reg;
  logic       b_start_next;
  logic       mtrig_reg;
  logic       mtrig_next;
  logic       btrig_reg;
  logic       btrig_next;
  logic [5:0] pwm_reg;
  logic [5:0] pwm_next;
  logic [5:0] gpio_lvl;
  logic       ch3_in;
  logic       master_ev;
  logic       b_ev;

  // ========================================================
  // gpio pins pass four flops (three stages and the level register)
  genvar g;
  generate
    for (g = 0; g < `PWM_CHANNELS; g = g + 1)
    begin : gpio_sync
      pin_sync3 u_sync
      (
        .clk_i   (clk_i),
        .arst_n_i(arst_n_i),
        .pin_i   (gpio_pin_i[g]),
        .level_o (gpio_lvl[g])
      );
    end
  endgenerate

  // edge to single-cycle pulse
  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction : rise

  // channel-3 input mux
  assign ch3_in = sel_reg ? pwm_reload_sync_i : timer_ch3_pin_i;

  // trigger events from timer outputs
  assign master_ev = rise(timer_ch3_out_i, ch3_prev_reg);
  assign b_ev      = rise(timer_ch2_out_i, ch2_prev_reg);

  // next-state of selects, triggers and pwm outputs
  always_comb
  begin
    sel_next      = timer_sel_reload_i;
    mode_next     = conv_mode_i;
    src_next      = pwm_src_i;
    ch3_prev_next = timer_ch3_out_i;
    ch2_prev_next = timer_ch2_out_i;
    mtrig_next    = master_ev;
    btrig_next    = b_ev;
    a_start_next  = 1'h0;
    b_start_next  = 1'h0;
    if (master_ev && mode_reg != `MODE_PARALLEL_INDEP)
    begin
      a_start_next = 1'h1;
      b_start_next = 1'h1;
    end
    if (b_ev && mode_reg == `MODE_PARALLEL_INDEP)
      b_start_next = 1'h1;
    if (master_ev && mode_reg == `MODE_PARALLEL_INDEP)
      a_start_next = 1'h1;
    unique case (src_reg)
      `PWM_SRC_LIMIT:  pwm_next = conv_over_limit_i & ~conv_under_limit_i;
      `PWM_SRC_TIMER:  pwm_next = timer_out_i;
      `PWM_SRC_GPIO:   pwm_next = gpio_lvl;
      default:         pwm_next = pwm_gen_i;
    endcase
  end

  // registers; reset routes the channel-3 pin and the pwm generator
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sel_reg      <= `RESET_TIMER_SEL;
      mode_reg     <= `MODE_SEQUENTIAL;
      src_reg      <= `RESET_PWM_SRC;
      ch3_prev_reg <= 1'h0;
      ch2_prev_reg <= 1'h0;
      a_start_reg  <= 1'h0;
      b_start_reg  <= 1'h0;
      mtrig_reg    <= 1'h0;
      btrig_reg    <= 1'h0;
      pwm_reg      <= 6'h00;
    end
    else
    begin
      sel_reg      <= sel_next;
      mode_reg     <= mode_next;
      src_reg      <= src_next;
      ch3_prev_reg <= ch3_prev_next;
      ch2_prev_reg <= ch2_prev_next;
      a_start_reg  <= a_start_next;
      b_start_reg  <= b_start_next;
      mtrig_reg    <= mtrig_next;
      btrig_reg    <= btrig_next;
      pwm_reg      <= pwm_next;
    end
  end

  // outputs
  assign timer_ch3_in_o     = ch3_in;
  assign conv_a_start_o     = a_start_reg;
  assign conv_b_start_o     = b_start_reg;
  assign conv_master_trig_o = mtrig_reg;
  assign conv_b_trig_o      = btrig_reg;
  assign pwm_out_o          = pwm_reg;

  // ========================================================
  // assertions
  a_ch3_mux_sel: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     ($past(timer_sel_reload_i) && $past(arst_n_i))
     |-> timer_ch3_in_o == pwm_reload_sync_i)
    else $error("channel 3 input not reload pulse");
  a_master_trig: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     $rose(timer_ch3_out_i) |=> conv_master_trig_o)
    else $error("master trigger missed");
  a_b_trig: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     $rose(timer_ch2_out_i) |=> conv_b_trig_o)
    else $error("converter b trigger missed");
  a_both_start: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     ($rose(timer_ch3_out_i) && mode_reg != `MODE_PARALLEL_INDEP)
     |=> conv_a_start_o && conv_b_start_o)
    else $error("both converters not started");
  a_b_only: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     (conv_b_trig_o && !conv_master_trig_o && mode_reg != `MODE_PARALLEL_INDEP
      && $past(mode_reg) == mode_reg) |-> !conv_b_start_o)
    else $error("b trigger outside independent mode");
  a_b_indep: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     ($rose(timer_ch2_out_i) && mode_reg == `MODE_PARALLEL_INDEP)
     |=> conv_b_start_o)
    else $error("converter b not started in independent mode");
  a_pwm_timer: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     src_reg == `PWM_SRC_TIMER |=> pwm_out_o == $past(timer_out_i))
    else $error("pwm not driven by timer");
  a_sel_follow: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     1'b1 |=> src_reg == $past(pwm_src_i))
    else $error("select bits not taken");
  a_pulse_single: assert property
    (@(posedge clk_i) disable iff (!arst_n_i)
     conv_master_trig_o |=> !conv_master_trig_o)
    else $error("trigger wider than one cycle");
  c_master: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    conv_a_start_o && conv_b_start_o);
  c_b_only: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    conv_b_start_o && !conv_a_start_o);
  c_gpio_src: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    src_reg == `PWM_SRC_GPIO && |pwm_out_o);

endmodule : trig_route

`default_nettype wire

// >>> dv/timer_pwm_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// timer channel and reload pulse source; a fire gives one high cycle
module timer_pwm_model
(
  // clock
  input  wire logic       clk_i,
  // requests: bit 0 ch2, bit 1 ch3, bit 2 reload
  input  wire logic [2:0] fire_i,
  // active-high pulses, changed just after an edge
  output logic      [2:0] pulse_o
);
  // register the request so the pulse is clean of the bench delay
  always_ff @(posedge clk_i)
  begin
    pulse_o <= fire_i;
  end
endmodule : timer_pwm_model

`default_nettype wire

// >>> dv/pwm_timer_adc_trigger_routing_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "trig_route_defs.svh"

// ==========================================================
// self-checking bench for the trigger router
module pwm_timer_adc_trigger_routing_test;
  import trig_route_pkg::*;
  logic       clk_i, arst_n_i, sel, pin, ch3_in;
  logic       a_st, b_st, m_tr, b_tr;
  conv_mode_t mode;
  pwm_src_t   src;
  logic [2:0] fire, pulse;
  logic [5:0] gen, over, under, tmr, gpio, pwm;
  logic [7:0] cnt [4] = '{default: 8'h00};
  logic [7:0] base [4];
  logic [7:0] want;
  int         n_fail, compares;
  // rows: mode, ch3 fired, a start, b start, master, b trigger,
  // pwm source select, expected pwm out (4 and 7 fall back)
  logic [15:0] rows [6] = '{16'h3C15, 16'h7C70, 16'hB4AA,
                            16'h02F3, 16'h4315, 16'h8BD5};

  timer_pwm_model PEER (.clk_i(clk_i), .fire_i(fire), .pulse_o(pulse));

  trig_route DUT
  (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .timer_sel_reload_i(sel),
    .conv_mode_i(mode), .pwm_src_i(src), .timer_ch3_pin_i(pin),
    .timer_ch2_out_i(pulse[0]), .timer_ch3_out_i(pulse[1]),
    .timer_ch3_in_o(ch3_in), .pwm_reload_sync_i(pulse[2]),
    .pwm_gen_i(gen), .pwm_out_o(pwm), .conv_over_limit_i(over),
    .conv_under_limit_i(under), .timer_out_i(tmr), .gpio_pin_i(gpio),
    .conv_a_start_o(a_st), .conv_b_start_o(b_st),
    .conv_master_trig_o(m_tr), .conv_b_trig_o(b_tr)
  );

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // count high cycles of each start and trigger output
  always @(posedge clk_i)
  begin
    cnt[0] <= cnt[0] + a_st;
    cnt[1] <= cnt[1] + b_st;
    cnt[2] <= cnt[2] + m_tr;
    cnt[3] <= cnt[3] + b_tr;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // two pulses with one low cycle between them
  task automatic fire_twice(input int k);
    repeat (2)
    begin
      fire[k] = 1'b1;
      step(1);
      fire[k] = 1'b0;
      step(1);
    end
  endtask : fire_twice

  task automatic print_verdict;
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    arst_n_i = 1'b0;
    sel = 1'b0;
    pin = 1'b0;
    mode = `MODE_SEQUENTIAL;
    src = `PWM_SRC_GENERATOR;
    fire = 3'h0;
    gen = 6'h15;
    over = 6'h3C;
    under = 6'h0F;
    tmr = 6'h2A;
    gpio = 6'h33;
    n_fail = 0;
    compares = 0;
    step(2);
    arst_n_i = 1'b1;
    foreach (rows[i])
    begin
      mode = rows[i][15:14];
      src = rows[i][8:6];
      step(2);
      base = cnt;
      fire_twice(rows[i][13] ? 1 : 0);
      step(4);
      for (int j = 0; j < 4; j++)
      begin
        want = {6'h00, rows[i][12-j], 1'h0};
        check(cnt[j] - base[j], want);
      end
      check({2'h0, pwm}, {2'h0, rows[i][5:0]});
    end
    // channel-3 input: reload pulse when selected, pin otherwise
    sel = 1'b1;
    pin = 1'b1;
    step(2);
    check({7'h00, ch3_in}, 8'h00);
    fire[2] = 1'b1;
    step(1);
    check({7'h00, ch3_in}, 8'h01);
    fire[2] = 1'b0;
    sel = 1'b0;
    step(2);
    check({7'h00, ch3_in}, 8'h01);
    // reset in mid-run drops the select back to the pin
    sel = 1'b1;
    pin = 1'b0;
    step(2);
    arst_n_i = 1'b0;
    pin = 1'b1;
    #1;
    check({7'h00, ch3_in}, 8'h01);
    check({a_st, b_st, m_tr, b_tr, pwm[3:0]}, 8'h00);
    check({2'h0, pwm}, 8'h00);
    step(1);
    arst_n_i = 1'b1;
    step(1);
    check({7'h00, ch3_in}, 8'h00);
    print_verdict();
  end
endmodule : pwm_timer_adc_trigger_routing_test

`default_nettype wire
